// file: design/dlp_host_end.sv
// host controller end: video timing, pixel driver, converter writer
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module dlp_host_end
    import dlp_pkg::*;
#(
    parameter int H_ACT = H_ACTIVE,
    parameter int H_TOT = H_TOTAL,
    parameter int H_FP = H_FPORCH,
    parameter int H_SW = H_SYNC,
    parameter int V_ACT = V_ACTIVE,
    parameter int V_TOT = V_TOTAL,
    parameter int V_FP = V_FPORCH,
    parameter int V_SW = V_SYNC,
    parameter int Q_CYC = I2C_Q_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [NCH-1:0][PIX_W-1:0] i_pix_even,
    input wire logic [NCH-1:0][PIX_W-1:0] i_pix_odd,
    input wire logic i_pix_valid,
    output logic o_pix_ready,
    dlp_link_if.host link
);
    initial begin
        if (H_ACT < 1 || H_FP + H_SW + H_ACT >= H_TOT || H_TOT > 4095 ||
            V_ACT < 1 || V_FP + V_SW + V_ACT >= V_TOT || V_TOT > 4095 ||
            Q_CYC < 1)
            $error("dlp_host_end: bad timing parameters");
    end

    logic [3:0] div_q, div_d;
    logic [11:0] h_q, h_d, v_q, v_d, h_n, v_n;
    logic dclk_q, dclk_d, de_q, de_d, hs_q, hs_d, vs_q, vs_d, rdy_q, rdy_d;
    logic [NCH-1:0][PIX_W-1:0] pe_q, pe_d, po_q, po_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [6:0] tgt_q, tgt_d;
    logic nack_q, nack_d, refused_q, refused_d, under_q, under_d;
    logic [31:0] rdata_q, rdata_d;
    dlp_hm_st_t st_q, st_d;
    logic [15:0] qc_q, qc_d;
    logic [1:0] ph_q, ph_d;
    logic [4:0] idx_q, idx_d;
    logic [26:0] sh_q, sh_d, am_q, am_d;
    logic scl_q, scl_d, sdo_q, sdo_d;
    logic [1:0] sda_meta_q, sda_sync_q;
    logic tick, act_n, qtick;

    // one shared dot clock and one timing for both halves [R12]
    always_comb begin
        tick = (div_q == 4'(DOT_DIV - 1));
        h_n = (h_q == 12'(H_TOT - 1)) ? 12'h000 : h_q + 12'h001;
        v_n = v_q;
        if (h_q == 12'(H_TOT - 1))
            v_n = (v_q == 12'(V_TOT - 1)) ? 12'h000 : v_q + 12'h001;
        act_n = ctrl_q[CTRL_VID_BIT] && h_n < 12'(H_ACT) && v_n < 12'(V_ACT);
        div_d = tick ? 4'h0 : div_q + 4'h1;
        h_d = tick ? h_n : h_q;
        v_d = tick ? v_n : v_q;
        dclk_d = tick ? 1'b1 :
            (div_q == 4'(DOT_DIV / 2 - 1)) ? 1'b0 : dclk_q;
        rdy_d = (div_q == 4'(DOT_DIV - 2)) && act_n;
        de_d = de_q;
        hs_d = hs_q;
        vs_d = vs_q;
        pe_d = pe_q;
        po_d = po_q;
        under_d = under_q;
        if (i_wr && i_addr == REG_STATUS)
            under_d = 1'b0;
        if (tick) begin
            // data change with the rising edge, stable at the falling edge
            // the ready pulse decides, so no taken pair goes unshown; on underrun zeros are shown
            de_d = rdy_q; // [R09]
            hs_d = h_n >= 12'(H_ACT + H_FP) && h_n < 12'(H_ACT + H_FP + H_SW);
            vs_d = v_n >= 12'(V_ACT + V_FP) && v_n < 12'(V_ACT + V_FP + V_SW);
            pe_d = '0;
            po_d = '0;
            if (rdy_q && i_pix_valid) begin
                pe_d = i_pix_even; // even and right neighbour together [R10]
                po_d = i_pix_odd; // [R11]
            end
            if (rdy_q && !i_pix_valid)
                under_d = 1'b1;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        tgt_d = tgt_q;
        refused_d = refused_q;
        nack_d = nack_q;
        st_d = st_q;
        qc_d = qc_q;
        ph_d = ph_q;
        idx_d = idx_q;
        sh_d = sh_q;
        am_d = am_q;
        scl_d = scl_q;
        sdo_d = sdo_q;
        qtick = (qc_q == 16'(Q_CYC - 1));
        if (i_wr && i_addr == REG_CTRL)
            ctrl_d = i_wdata[1:0]; // backlight level follows bit 0 [R04]
        if (i_wr && i_addr == REG_TGT)
            tgt_d = i_wdata[6:0];
        if (i_wr && i_addr == REG_STATUS) begin
            refused_d = 1'b0;
            nack_d = 1'b0;
        end
        if (i_wr && i_addr == REG_DAC && st_q == HM_IDLE) begin
            if (dlp_is_reserved(tgt_q)) begin
                refused_d = 1'b1; // [R03]
            end else begin
                // address, port select command, level [R01] [R02]
                sh_d = {tgt_q, 1'b0, 1'b1, CMD_BASE, i_wdata[DAC_PORT_BIT],
                    1'b1, i_wdata[7:0], 1'b1};
                am_d = {9'h001, 9'h001, 9'h001};
                idx_d = 5'd26;
                st_d = HM_START;
                qc_d = '0;
                ph_d = 2'h0;
            end
        end else if (st_q != HM_IDLE) begin
            qc_d = qtick ? 16'h0000 : qc_q + 16'h0001;
            if (qtick) begin
                ph_d = ph_q + 2'h1;
                case (st_q)
                    HM_START: begin
                        if (ph_q == 2'h0) begin
                            scl_d = 1'b1;
                            sdo_d = 1'b0;
                        end
                        if (ph_q == 2'h2)
                            sdo_d = 1'b1;
                        if (ph_q == 2'h3) begin
                            scl_d = 1'b0;
                            st_d = HM_BITS;
                        end
                    end
                    HM_BITS: begin
                        if (ph_q == 2'h0)
                            sdo_d = !sh_q[idx_q];
                        if (ph_q == 2'h1)
                            scl_d = 1'b1;
                        if (ph_q == 2'h2 && am_q[idx_q] && sda_sync_q[1])
                            nack_d = 1'b1;
                        if (ph_q == 2'h3) begin
                            scl_d = 1'b0;
                            sdo_d = 1'b0; // free before any answer
                            idx_d = idx_q - 5'd1;
                            if (idx_q == 5'd0 || nack_q)
                                st_d = HM_STOP;
                        end
                    end
                    HM_STOP: begin
                        if (ph_q == 2'h0)
                            sdo_d = 1'b1;
                        if (ph_q == 2'h1)
                            scl_d = 1'b1;
                        if (ph_q == 2'h2)
                            sdo_d = 1'b0;
                        if (ph_q == 2'h3)
                            st_d = HM_IDLE;
                    end
                    default: st_d = HM_IDLE;
                endcase
            end
        end
        rdata_d = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                REG_CTRL: rdata_d = {30'h0, ctrl_q};
                REG_TGT: rdata_d = {25'h0, tgt_q};
                REG_STATUS: rdata_d = {28'h0, under_q, refused_q, nack_q,
                    st_q != HM_IDLE};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= 4'h0;
            h_q <= 12'h000;
            v_q <= 12'h000;
            dclk_q <= 1'b0;
            rdy_q <= 1'b0;
            de_q <= 1'b0;
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            pe_q <= '0;
            po_q <= '0;
            under_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            tgt_q <= DAC_ADDR;
            refused_q <= 1'b0;
            nack_q <= 1'b0;
            st_q <= HM_IDLE;
            qc_q <= 16'h0000;
            ph_q <= 2'h0;
            idx_q <= 5'd0;
            sh_q <= '0;
            am_q <= '0;
            scl_q <= 1'b1;
            sdo_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            sda_meta_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end else begin
            div_q <= div_d;
            h_q <= h_d;
            v_q <= v_d;
            dclk_q <= dclk_d;
            rdy_q <= rdy_d;
            de_q <= de_d;
            hs_q <= hs_d;
            vs_q <= vs_d;
            pe_q <= pe_d;
            po_q <= po_d;
            under_q <= under_d;
            ctrl_q <= ctrl_d;
            tgt_q <= tgt_d;
            refused_q <= refused_d;
            nack_q <= nack_d;
            st_q <= st_d;
            qc_q <= qc_d;
            ph_q <= ph_d;
            idx_q <= idx_d;
            sh_q <= sh_d;
            am_q <= am_d;
            scl_q <= scl_d;
            sdo_q <= sdo_d;
            rdata_q <= rdata_d;
            sda_meta_q <= {1'b0, link.control_serial_data};
            sda_sync_q <= {sda_meta_q[0], 1'b0};
        end
    end

    assign o_rdata = rdata_q;
    assign o_pix_ready = rdy_q;
    // both links of both channels share one clock and one timing [R06]
    assign link.even_link_clock = {NCH{dclk_q}};
    assign link.odd_link_clock = {NCH{dclk_q}};
    assign link.even_pix = pe_q;
    assign link.odd_pix = po_q;
    assign link.hsync = {NCH{hs_q}}; // flags ride the even link only [R05]
    assign link.vsync = {NCH{vs_q}};
    assign link.display_timing_flag = {NCH{de_q}};
    assign link.serial_clock = scl_q;
    assign link.host_sda_oe = sdo_q;
    assign link.backlight_enable = ctrl_q[CTRL_BL_BIT];
endmodule

// file: design/dlp_pkg.sv
// shared constants and types for the dual link panel input port
package dlp_pkg;
    localparam int CLK_NS = 10;
    localparam int PIX_W = 8;
    localparam int NCH = 2;
    localparam int CH_LEFT = 0;
    localparam int CH_RIGHT = 1;
    localparam logic [6:0] DAC_ADDR = 7'h2d;
    localparam logic [6:0] RSV_A_LO = 7'h10;
    localparam logic [6:0] RSV_A_HI = 7'h1f;
    localparam logic [6:0] RSV_B_LO = 7'h30;
    localparam logic [6:0] RSV_B_HI = 7'h3f;
    localparam logic PORT_CONTRAST = 1'b0;
    localparam logic PORT_BRIGHT = 1'b1;
    localparam logic [6:0] CMD_BASE = 7'h00;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DAC = 4'h1;
    localparam logic [3:0] REG_TGT = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam int CTRL_BL_BIT = 0;
    localparam int CTRL_VID_BIT = 1;
    localparam int DAC_PORT_BIT = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NACK_BIT = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_UNDERRUN_BIT = 3;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int DOT_DIV = 8;
    localparam int I2C_BIT_NS = 10000;
    localparam int I2C_Q_CYC = (I2C_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    localparam int H_ACTIVE = 512;
    localparam int H_TOTAL = 672;
    localparam int H_FPORCH = 12;
    localparam int H_SYNC = 32;
    localparam int V_ACTIVE = 1536;
    localparam int V_TOTAL = 1612;
    localparam int V_FPORCH = 6;
    localparam int V_SYNC = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int WORD_W = 2 * PIX_W + 2;
    typedef enum logic [1:0] {HM_IDLE, HM_START, HM_BITS, HM_STOP} dlp_hm_st_t;
    typedef enum logic [1:0] {TS_IDLE, TS_RX, TS_ACK} dlp_ts_st_t;
    function automatic logic dlp_is_reserved(input logic [6:0] a);
        return (a >= RSV_A_LO && a <= RSV_A_HI) ||
               (a >= RSV_B_LO && a <= RSV_B_HI);
    endfunction
endpackage

// file: design/dlp_link_if.sv
// link between host controller and panel input port
`timescale 1ns/10ps
interface dlp_link_if;
    import dlp_pkg::*;
    logic [NCH-1:0] even_link_clock;
    logic [NCH-1:0] odd_link_clock;
    logic [NCH-1:0][PIX_W-1:0] even_pix;
    logic [NCH-1:0][PIX_W-1:0] odd_pix;
    logic [NCH-1:0] hsync;
    logic [NCH-1:0] vsync;
    logic [NCH-1:0] display_timing_flag;
    logic serial_clock;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic control_serial_data;
    logic backlight_enable;
    // open drain with pull-up: low whenever either end drives
    assign control_serial_data = !(host_sda_oe || dev_sda_oe);
    modport host (
        output even_link_clock, odd_link_clock, even_pix, odd_pix,
        output hsync, vsync, display_timing_flag,
        output serial_clock, host_sda_oe, backlight_enable,
        input control_serial_data
    );
    modport dev (
        input even_link_clock, odd_link_clock, even_pix, odd_pix,
        input hsync, vsync, display_timing_flag,
        input serial_clock, backlight_enable, control_serial_data,
        output dev_sda_oe
    );
endinterface

// file: design/dlp_dev_end.sv
// panel end: link capture, pixel fifo, converter target, backlight
`timescale 1ns/10ps
// Summary of operation
// [R01] converter answers only target address 0101101
// [R02] port zero contrast, port one brightness
// [R03] host avoids reserved address ranges 10h and 30h
// [R04] backlight on while enable input high
// [R05] even pair two carries sync and timing
// [R06] even and odd links, own clock each
// [R07] master carries left and serial port
// [R08] voltage outputs follow last written port value
// [R09] pixels taken at falling edge, flag high
// [R10] even pixel and right neighbour together
// [R11] each channel drives only its own half
// [R12] host keeps both channels frame locked
module dlp_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
            $error("dlp_fifo: depth must be a power of two");
    end
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;
    always_comb begin
        o_in_ready = (wp_q - rp_q) != (AW + 1)'(DEPTH);
        o_out_valid = wp_q != rp_q;
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end
    assign o_out_data = mem[rp_q[AW-1:0]];
    always_ff @(posedge i_core_clk) begin
        if (push)
            mem[wp_q[AW-1:0]] <= i_in_data;
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
endmodule

module dlp_dev_end
    import dlp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    dlp_link_if.dev link,
    output logic [NCH-1:0] o_pix_valid,
    input wire logic [NCH-1:0] i_pix_ready,
    output logic [NCH-1:0][WORD_W-1:0] o_pix_data,
    output logic [NCH-1:0] o_overflow,
    output logic [PIX_W-1:0] o_contrast_level,
    output logic [PIX_W-1:0] o_brightness_level,
    output logic o_backlight_on
);
    localparam int LW = 3 + 2 * PIX_W + 2;
    localparam int SW = NCH * LW + 3;
    logic [SW-1:0] meta_q, sync_q, prev_q;
    logic [SW-1:0] raw;
    logic scl_s, sda_s, scl_p, sda_p;

    always_comb begin
        raw = {link.serial_clock, link.control_serial_data,
            link.backlight_enable, {NCH * LW{1'b0}}};
        for (int c = 0; c < NCH; c++)
            raw[c*LW +: LW] = {link.even_link_clock[c],
                link.odd_link_clock[c], link.display_timing_flag[c],
                link.hsync[c], link.vsync[c], link.even_pix[c],
                link.odd_pix[c]};
    end

    // two stages before any logic looks at a pin
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // channel 0 is the left master connector, 1 the right slave [R07]
        logic [LW-1:0] s, p;
        logic efall, ofall, push, rdy, fv, take;
        logic [PIX_W-1:0] odd_q, odd_d, odd_now;
        logic de_q, de_d, sof_q, sof_d, ovf_q, ovf_d, ov_q, ov_d;
        logic [WORD_W-1:0] w, fd, od_q, od_d;
        assign s = sync_q[c*LW +: LW];
        assign p = prev_q[c*LW +: LW];
        always_comb begin
            efall = p[LW-1] && !s[LW-1]; // [R09]
            ofall = p[LW-2] && !s[LW-2]; // each clock times its own link [R06]
            odd_now = ofall ? s[PIX_W-1:0] : odd_q;
            odd_d = odd_now;
            // flags are taken from the even link only [R05]
            push = efall && s[LW-3];
            de_d = efall ? s[LW-3] : de_q;
            sof_d = sof_q;
            if (efall && s[LW-5])
                sof_d = 1'b1;
            if (push)
                sof_d = 1'b0;
            // pair word: frame start, line start, odd, even [R10]
            w = {sof_q, !de_q, odd_now, s[2*PIX_W-1:PIX_W]};
            // the link cannot be stalled, so a full fifo drops and flags
            ovf_d = ovf_q || (push && !rdy);
            take = !ov_q || i_pix_ready[c];
            ov_d = take ? fv : ov_q;
            od_d = (take && fv) ? fd : od_q;
        end
        dlp_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_in_valid(push),
            .o_in_ready(rdy),
            .i_in_data(w),
            .o_out_valid(fv),
            .i_out_ready(take),
            .o_out_data(fd)
        );
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                odd_q <= '0;
                de_q <= 1'b0;
                sof_q <= 1'b0;
                ovf_q <= 1'b0;
                ov_q <= 1'b0;
                od_q <= '0;
            end else begin
                odd_q <= odd_d;
                de_q <= de_d;
                sof_q <= sof_d;
                ovf_q <= ovf_d;
                ov_q <= ov_d;
                od_q <= od_d;
            end
        end
        // each half gets its own output stream [R11]
        assign o_pix_valid[c] = ov_q;
        assign o_pix_data[c] = od_q;
        assign o_overflow[c] = ovf_q;
    end

    assign scl_s = sync_q[SW-1];
    assign sda_s = sync_q[SW-2];
    assign scl_p = prev_q[SW-1];
    assign sda_p = prev_q[SW-2];

    dlp_ts_st_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] byte_q, byte_d;
    logic [7:0] sh_q, sh_d;
    logic port_q, port_d, oe_q, oe_d, bl_q, bl_d;
    logic [PIX_W-1:0] con_q, con_d, bri_q, bri_d;
    logic rise, fall, start, stop;

    always_comb begin
        rise = scl_s && !scl_p;
        fall = !scl_s && scl_p;
        start = scl_s && scl_p && sda_p && !sda_s;
        stop = scl_s && scl_p && !sda_p && sda_s;
        st_d = st_q;
        bit_d = bit_q;
        byte_d = byte_q;
        sh_d = sh_q;
        port_d = port_q;
        oe_d = oe_q;
        con_d = con_q;
        bri_d = bri_q;
        bl_d = sync_q[SW-3]; // [R04]
        if (start) begin
            st_d = TS_RX;
            bit_d = 4'h0;
            byte_d = 2'h0;
            oe_d = 1'b0;
        end else if (stop) begin
            st_d = TS_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                TS_IDLE: oe_d = 1'b0;
                TS_RX: begin
                    if (rise && bit_q != 4'h8) begin
                        sh_d = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'h1;
                    end
                    if (fall && bit_q == 4'h8) begin
                        st_d = TS_ACK;
                        oe_d = 1'b1;
                        if (byte_q == 2'h0 &&
                            (sh_q[7:1] != DAC_ADDR || sh_q[0])) begin
                            st_d = TS_IDLE; // [R01]
                            oe_d = 1'b0;
                        end
                        if (byte_q == 2'h1)
                            port_d = sh_q[0];
                        if (byte_q == 2'h2) begin
                            // level applies when its port is written [R08]
                            if (port_q == PORT_BRIGHT)
                                bri_d = sh_q; // [R02]
                            else
                                con_d = sh_q;
                        end
                    end
                end
                TS_ACK: begin
                    if (fall) begin
                        oe_d = 1'b0;
                        bit_d = 4'h0;
                        byte_d = (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
                        st_d = TS_RX;
                    end
                end
                default: st_d = TS_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= TS_IDLE;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            sh_q <= 8'h00;
            port_q <= PORT_CONTRAST;
            oe_q <= 1'b0;
            con_q <= LEVEL_RST;
            bri_q <= LEVEL_RST;
            bl_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            sh_q <= sh_d;
            port_q <= port_d;
            oe_q <= oe_d;
            con_q <= con_d;
            bri_q <= bri_d;
            bl_q <= bl_d;
        end
    end

    assign link.dev_sda_oe = oe_q;
    assign o_contrast_level = con_q;
    assign o_brightness_level = bri_q;
    assign o_backlight_on = bl_q;
endmodule

// file: tb/dlp_checker.sv
// link protocol assertions for the dual link panel port
`timescale 1ns/10ps
module dlp_checker
    import dlp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [NCH-1:0] even_link_clock,
    input wire logic [NCH-1:0] odd_link_clock,
    input wire logic [NCH-1:0] hsync,
    input wire logic [NCH-1:0] vsync,
    input wire logic [NCH-1:0] display_timing_flag,
    input wire logic serial_clock,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_odd_clock_same: assert property (odd_link_clock == even_link_clock)
        else $error("odd clock apart from even clock");
    chk_channel_lock: assert property (even_link_clock[1] == even_link_clock[0]
        && hsync[1] == hsync[0] && vsync[1] == vsync[0]
        && display_timing_flag[1] == display_timing_flag[0])
        else $error("channels not frame locked");
    chk_clock_high: assert property ($rose(even_link_clock[0]) |=>
        even_link_clock[0] [*3] ##1 !even_link_clock[0])
        else $error("dot clock high phase wrong");
    chk_clock_low: assert property ($fell(even_link_clock[0]) |=>
        !even_link_clock[0] [*3] ##1 even_link_clock[0])
        else $error("dot clock low phase wrong");
    // flags may only move with the rising edge, so the fall sees them settled
    chk_flag_launch: assert property (!$rose(even_link_clock[0]) |->
        $stable(display_timing_flag) && $stable(hsync) && $stable(vsync))
        else $error("flags moved away from rising edge");
    chk_sync_blank: assert property ((hsync[0] || vsync[0]) |-> !display_timing_flag[0])
        else $error("sync inside displayed area");
    chk_ack_turn: assert property (dev_sda_oe |-> !host_sda_oe)
        else $error("both ends pull data");
    chk_ack_edge: assert property ($changed(dev_sda_oe) |-> !serial_clock)
        else $error("target moved data with clock high");
endmodule

// file: tb/dual_link_panel_input_port_tb.sv
// bench joining host end and panel end over the link
`timescale 1ns/10ps
module dual_link_panel_input_port_tb;
    import dlp_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, pv = 0, bl, prq;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [NCH-1:0][PIX_W-1:0] pe = 16'h8000, po;
    logic [NCH-1:0] pvo, ovf, prdy = '1, cmp = '1;
    logic [NCH-1:0][WORD_W-1:0] pdo;
    logic [7:0] con, bri;
    logic [16:0] q[NCH][$];
    logic [6:0] rsv[4] = '{7'h10, 7'h1f, 7'h30, 7'h3f};
    int n_errors = 0, n_checks = 0, since = 9;
    dlp_link_if u_dlp_link_if();
    // short timing keeps a frame at 1536 dots
    dlp_host_end #(.H_ACT(16), .H_TOT(64), .V_ACT(4), .V_TOT(24),
        .Q_CYC(4)) u_dlp_host_end (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pix_even(pe),
        .i_pix_odd(po), .i_pix_valid(pv), .o_pix_ready(prq),
        .link(u_dlp_link_if.host));
    dlp_dev_end u_dlp_dev_end (.i_core_clk(clk), .i_rst_n(rst_n),
        .link(u_dlp_link_if.dev), .o_pix_valid(pvo), .i_pix_ready(prdy),
        .o_pix_data(pdo), .o_overflow(ovf), .o_contrast_level(con),
        .o_brightness_level(bri), .o_backlight_on(bl));
    dlp_checker u_dlp_checker (.i_core_clk(clk), .i_rst_n(rst_n),
        .even_link_clock(u_dlp_link_if.even_link_clock),
        .odd_link_clock(u_dlp_link_if.odd_link_clock),
        .hsync(u_dlp_link_if.hsync), .vsync(u_dlp_link_if.vsync),
        .display_timing_flag(u_dlp_link_if.display_timing_flag),
        .serial_clock(u_dlp_link_if.serial_clock),
        .host_sda_oe(u_dlp_link_if.host_sda_oe),
        .dev_sda_oe(u_dlp_link_if.dev_sda_oe));
    assign po = ~pe;
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic dac(logic p, logic [7:0] lv);
        logic [31:0] s;
        wr_reg(REG_DAC, {23'h0, p, lv});
        for (int i = 0; i < 1000; i++) begin
            rd_reg(REG_STATUS, s);
            if (s[ST_BUSY_BIT] === 1'b0)
                return;
        end
        chk("idle wait", 0, 1);
        wrap_up();
    endtask
    // the host keeps every pair it takes; the panel must hand them out in order
    always @(posedge clk) if (prq && pv) begin
        for (int c = 0; c < NCH; c++)
            q[c].push_back({since > 7, po[c], pe[c]});
        pe <= {pe[0] + 8'h81, pe[0] + 8'h01};
    end
    always @(posedge clk) since <= (prq && pv) ? 0 : since + 1;
    always @(posedge clk) for (int c = 0; c < NCH; c++)
        if (pvo[c] && prdy[c] && cmp[c])
            chk("pixel pair", 32'(pdo[c][16:0]), 32'(q[c].pop_front()));
    initial forever #5 clk = ~clk;
    initial begin
        logic [31:0] d;
        repeat (6) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd_reg(REG_TGT, d);
        chk("target reset", d, 32'h2d);
        rd_reg(4'hf, d);
        chk("unmapped read", d, 0);
        wr_reg(REG_CTRL, 32'h1);
        repeat (6) @(posedge clk);
        chk("backlight on", 32'(bl), 1);
        dac(PORT_CONTRAST, 8'h5a);
        chk("contrast", 32'(con), 32'h5a);
        chk("brightness", 32'(bri), 0);
        dac(PORT_BRIGHT, 8'hc3);
        chk("brightness", 32'(bri), 32'hc3);
        wr_reg(REG_TGT, 32'h2c);
        dac(PORT_BRIGHT, 8'h11);
        rd_reg(REG_STATUS, d);
        chk("nack", 32'(d[ST_NACK_BIT]), 1);
        chk("brightness kept", 32'(bri), 32'hc3);
        $display("converter test done");
        foreach (rsv[i]) begin
            wr_reg(REG_STATUS, 0);
            wr_reg(REG_TGT, 32'(rsv[i]));
            dac(PORT_CONTRAST, 8'h01);
            rd_reg(REG_STATUS, d);
            chk("refused", d[3:0], 32'h4);
        end
        $display("reserved test done");
        pv <= 1;
        wr_reg(REG_CTRL, 32'h2);
        repeat (6) @(posedge clk);
        chk("backlight off", 32'(bl), 0);
        repeat (4000) @(posedge clk);
        chk("no overflow", 32'(ovf), 0);
        // right channel stalls alone; the left one must not notice
        cmp <= 2'b01;
        prdy <= 2'b01;
        for (int i = 0; i < 30000 && ovf[1] !== 1'b1; i++)
            @(posedge clk);
        chk("overflow", 32'(ovf), 32'h2);
        $display("video test done");
        wrap_up();
    end
endmodule
